//--- hdl/ckg_clock_gen.sv
// Processor-side clock generator: PLL models, CPU family, dividers, fabric clocks, APB registers
module ckg_clock_gen
    import ckg_pkg::*;
#(
    parameter int NUM_PORTS  = 4, // Fabric port clocks watched
    parameter int NUM_PERIPH = 4  // Peripheral clock dividers
)(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [11:0]           paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  system_ref_clock,
    input  wire logic [NUM_PORTS-1:0]  port_clk,
    output logic                       cpu_clock_fastest,
    output logic                       cpu_clock_second,
    output logic                       cpu_clock_third,
    output logic                       cpu_clock_slowest,
    output logic                       memory_clock_fast,
    output logic                       memory_clock_slow,
    output logic      [NUM_PERIPH-1:0] periph_clock,
    output logic      [3:0]            fabric_clock_out,
    output logic      [3:0]            fabric_reset_out_n
);

    // ==================================================================
    // Elaboration checks
    initial
    begin
        if (NUM_PORTS < 1 || NUM_PORTS > 4 || NUM_PERIPH < 1 || NUM_PERIPH > 4)
            $error("NUM_PORTS and NUM_PERIPH must lie in 1..4");
    end

    localparam int FB0   = 2 + NUM_PERIPH; // First fabric divider index
    localparam int N_DIV = FB0 + 4;        // Total divider count

    // ==================================================================
    // Helper functions
    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                res[8*b +: 8] = new_v[8*b +: 8];
        return res;
    endfunction

    // Last tick of a half period; a divider of zero acts as one
    function automatic logic div_end(input logic [7:0] cnt, input logic [7:0] div);
        return ({1'b0, cnt} + 9'h001) >= {1'b0, div};
    endfunction

    // ==================================================================
    // Registers and state
    ckg_pll_cfg_s             pll_cfg_r [3];      // Software PLL settings
    ckg_pll_cfg_s             pll_act_r [3];      // Settings in use
    logic [15:0]              pll_acc_r [3];      // Phase accumulators
    logic [7:0]               lock_cnt_r [3];     // Reference edges since restart
    logic [2:0]               pll_tick_r;         // PLL output ticks
    logic                     ratio_r;            // 1 selects 4:2:2:1
    logic                     ratio_act_r;        // Ratio in use
    logic [3:0]               cpu_cnt_r;          // CPU family phase
    logic [3:0]               cpu_clk_r;          // CPU family outputs
    logic [15:0]              mem_div_r;          // Memory dividers
    logic [31:0]              per_div_r;          // Peripheral dividers
    ckg_fab_cfg_s             fab_cfg_r [4];      // Fabric settings
    logic                     ls_en_r;            // Level shifters enabled
    logic [7:0]               dcnt_r [N_DIV];     // Divider counters
    logic [7:0]               ddiv_r [N_DIV];     // Divider value in use
    logic [1:0]               dsrc_r [N_DIV];     // Source in use
    logic [N_DIV-1:0]         dout_r;             // Divider outputs
    logic [3:0]               frst_r;             // Fabric reset outputs, active low
    logic [2:0]               ref_sync_r;         // Reference clock sampler
    logic [NUM_PORTS-1:0]     port_s1_r;          // Port clock first stage
    logic [NUM_PORTS-1:0]     port_s2_r;          // Port clock second stage
    logic [NUM_PORTS-1:0]     port_s3_r;          // Port clock edge history
    logic [NUM_PORTS-1:0]     alive_r;            // Port clock seen toggling

    // ==================================================================
    // APB decode
    wire        setup_w   = psel & ~penable;
    wire        wr_w      = psel & penable & pwrite;
    wire [9:0]  word_w    = paddr[11:2];
    wire        hit_ratio = (word_w == CKG_CPU_RATIO_OFS[11:2]);
    wire        hit_mem   = (word_w == CKG_MEM_DIV_OFS[11:2]);
    wire        hit_per   = (word_w == CKG_PERIPH_DIV_OFS[11:2]);
    wire        hit_ls    = (word_w == CKG_LS_CTRL_OFS[11:2]);
    wire        hit_stat  = (word_w == CKG_STATUS_OFS[11:2]);
    wire [1:0]  pll_idx   = word_w[1:0];
    wire        hit_pll   = (word_w[9:2] == CKG_PLL_BASE_OFS[11:4]) && (pll_idx != 2'h3);
    wire [1:0]  fab_idx   = word_w[1:0];
    wire        hit_fab   = (word_w[9:2] == CKG_FAB_BASE_OFS[11:4]);
    wire        hit_any   = hit_ratio | hit_mem | hit_per | hit_ls | hit_stat | hit_pll | hit_fab;
    wire [2:0]  locked_w;
    wire [31:0] pll_word  = {pll_cfg_r[pll_idx].inc, 14'h0000, pll_cfg_r[pll_idx].bypass,
                             pll_cfg_r[pll_idx].en};
    wire [31:0] fab_word  = {15'h0000, fab_cfg_r[fab_idx].rst, fab_cfg_r[fab_idx].div,
                             6'h00, fab_cfg_r[fab_idx].src};
    wire [31:0] stat_word = {24'h000000, 4'(alive_r), ls_en_r, locked_w};
    wire [31:0] rd_word   = hit_pll   ? pll_word :
                            hit_fab   ? fab_word :
                            hit_ratio ? {31'h00000000, ratio_r} :
                            hit_mem   ? {16'h0000, mem_div_r} :
                            hit_per   ? per_div_r :
                            hit_ls    ? {31'h00000000, ls_en_r} :
                            hit_stat  ? stat_word : 32'h00000000;
    wire [31:0] pll_wr    = lane_merge(pll_word, pwdata, pstrb);
    wire [31:0] fab_wr    = lane_merge(fab_word, pwdata, pstrb);

    assign pready  = 1'b1; // Zero-wait slave

    // ==================================================================
    // Software registers, read data and error answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 3; i++)
                pll_cfg_r[i] <= '{en: 1'b1, bypass: 1'b1, inc: CKG_PLL_INC_RST};
            for (int j = 0; j < 4; j++)
                fab_cfg_r[j] <= '{src: 2'h0, div: CKG_FAB_DIV_RST, rst: 1'b0};
            ratio_r   <= 1'b0;
            mem_div_r <= {CKG_DIV_RST, CKG_DIV_RST};
            per_div_r <= {4{CKG_DIV_RST}};
            ls_en_r   <= 1'b0;
            prdata    <= 32'h00000000;
            pslverr   <= 1'b0;
        end
        else
        begin
            if (setup_w) // Read data and error captured in the setup cycle
            begin
                prdata  <= (hit_any && !pwrite) ? rd_word : 32'h00000000;
                pslverr <= ~hit_any; // Unmapped address
            end
            if (wr_w)
            begin
            if (hit_pll) // One PLL per word, others untouched
                pll_cfg_r[pll_idx] <= '{en: pll_wr[CKG_PLL_EN_BIT], bypass: pll_wr[CKG_PLL_BYP_BIT],
                                        inc: pll_wr[CKG_PLL_INC_LSB +: 16]};
            if (hit_fab) // Per fabric clock source and divider
                fab_cfg_r[fab_idx] <= '{src: fab_wr[1:0], div: fab_wr[CKG_FAB_DIV_LSB +: 8],
                                        rst: fab_wr[CKG_FAB_RST_BIT]};
            if (hit_ratio && pstrb[0])
                ratio_r <= pwdata[0];
            if (hit_mem)
                mem_div_r <= 16'(lane_merge({16'h0000, mem_div_r}, pwdata, pstrb));
            if (hit_per)
                per_div_r <= lane_merge(per_div_r, pwdata, pstrb);
            if (hit_ls && pstrb[0])
                ls_en_r <= pwdata[0];
            end
        end
    end

    // ==================================================================
    // Reference clock and port clock synchronisers
    wire                 ref_edge = ref_sync_r[1] & ~ref_sync_r[2];
    wire [NUM_PORTS-1:0] port_edge = port_s2_r ^ port_s3_r;
    wire                 alive_clr = wr_w & hit_stat & pstrb[0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_sync_r <= 3'h0;
            port_s1_r  <= '0;
            port_s2_r  <= '0;
            port_s3_r  <= '0;
            alive_r    <= '0;
        end
        else
        begin
            ref_sync_r <= {ref_sync_r[1:0], system_ref_clock};
            port_s1_r  <= port_clk;  // Each port clock crossed on its own
            port_s2_r  <= port_s1_r;
            port_s3_r  <= port_s2_r;
            // Toggle seen sets, write one clears, set wins
            alive_r    <= (alive_r & ~(alive_clr ? pwdata[CKG_STAT_ALIVE_LSB +: NUM_PORTS] : '0))
                          | port_edge;
        end
    end

    // ==================================================================
    // PLL models: accumulator ticks after lock, reference edges in bypass
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_pll
            wire        chg_w = (pll_act_r[g] != pll_cfg_r[g]);
            wire [16:0] sum_w = {1'b0, pll_acc_r[g]} + {1'b0, pll_act_r[g].inc};
            assign locked_w[g] = (lock_cnt_r[g] == CKG_LOCK_EDGES);

            // Settings change restarts lock, so no tick comes from a half-set PLL
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pll_act_r[g]  <= '{en: 1'b1, bypass: 1'b1, inc: CKG_PLL_INC_RST};
                    pll_acc_r[g]  <= 16'h0000;
                    lock_cnt_r[g] <= 8'h00;
                    pll_tick_r[g] <= 1'b0;
                end
                else
                begin
                    pll_act_r[g] <= pll_cfg_r[g];
                    if (chg_w || !pll_act_r[g].en)
                        lock_cnt_r[g] <= 8'h00;
                    else if (ref_edge && !locked_w[g]) // Lock counted on reference edges
                        lock_cnt_r[g] <= lock_cnt_r[g] + 8'h01;
                    pll_acc_r[g]  <= (pll_act_r[g].en && !pll_act_r[g].bypass) ? sum_w[15:0] : 16'h0000;
                    pll_tick_r[g] <= pll_act_r[g].en && !chg_w &&
                                     (pll_act_r[g].bypass ? ref_edge
                                                          : (locked_w[g] & sum_w[16]));
                end
            end
        end
    endgenerate

    // ==================================================================
    // CPU family: one phase counter drives all four outputs
    wire [3:0] cpu_lim  = ratio_act_r ? CKG_CPU_LIM_421 : CKG_CPU_LIM_621;
    wire       cpu_wrap = (cpu_cnt_r == cpu_lim);
    wire [3:0] cpu_nxt  = cpu_wrap ? 4'h0 : cpu_cnt_r + 4'h1;
    wire [3:0] cpu_half = 4'((cpu_lim + 4'h1) >> 1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_cnt_r   <= 4'h0;
            cpu_clk_r   <= 4'h0;
            ratio_act_r <= 1'b0;
        end
        else if (pll_tick_r[0])
        begin
            cpu_cnt_r <= cpu_nxt;
            if (cpu_wrap) // Ratio changes only at a whole slowest period
                ratio_act_r <= ratio_r;
            cpu_clk_r[3] <= (cpu_nxt % 4'h2) == 4'h0;
            cpu_clk_r[2] <= (cpu_nxt % 4'h4) < 4'h2;
            // Third clock at one third or one half of fastest
            cpu_clk_r[1] <= ratio_act_r ? ((cpu_nxt % 4'h4) < 4'h2) : ((cpu_nxt % 4'h6) < 4'h3);
            cpu_clk_r[0] <= cpu_nxt < cpu_half;
        end
    end

    assign cpu_clock_fastest = cpu_clk_r[3];
    assign cpu_clock_second  = cpu_clk_r[2];
    assign cpu_clock_third   = cpu_clk_r[1];
    assign cpu_clock_slowest = cpu_clk_r[0];

    // ==================================================================
    // Divider bank: memory, peripheral and fabric clocks
    logic [7:0]       dcfg_div [N_DIV]; // Requested divider
    logic [1:0]       dcfg_src [N_DIV]; // Requested source
    logic [N_DIV-1:0] dtick;            // Source tick per divider
    logic [N_DIV-1:0] dhold;            // Held low and cleared
    logic [N_DIV-1:0] dend;             // Half period ends this tick

    always_comb
    begin
        for (int k = 0; k < N_DIV; k++)
        begin
            dcfg_src[k] = 2'h0;
            dhold[k]    = 1'b0;
            if (k < 2) // Own dividers on the DDR PLL
            begin
                dcfg_div[k] = mem_div_r[8*k +: 8];
                dtick[k]    = pll_tick_r[1];
            end
            else if (k < FB0) // Own divider per peripheral on the I/O PLL
            begin
                dcfg_div[k] = per_div_r[8*(k-2) +: 8];
                dtick[k]    = pll_tick_r[2];
            end
            else
            begin
                dcfg_div[k] = fab_cfg_r[k-FB0].div;
                dcfg_src[k] = fab_cfg_r[k-FB0].src;
                dhold[k]    = ~ls_en_r; // No toggling before shifters enabled
                dtick[k]    = (dsrc_r[k] == CKG_SRC_CPU) ? pll_tick_r[0] :
                              (dsrc_r[k] == CKG_SRC_DDR) ? pll_tick_r[1] : pll_tick_r[2];
            end
            dend[k] = div_end(dcnt_r[k], ddiv_r[k]);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int k = 0; k < N_DIV; k++)
            begin
                dcnt_r[k] <= 8'h00;
                ddiv_r[k] <= CKG_DIV_RST;
                dsrc_r[k] <= 2'h0;
            end
            dout_r <= '0;
        end
        else
        begin
            for (int k = 0; k < N_DIV; k++)
            begin
                if (dhold[k] || (!dout_r[k] && dcnt_r[k] == 8'h00))
                begin
                    // New settings only at the start of a low phase
                    ddiv_r[k] <= dcfg_div[k];
                    dsrc_r[k] <= dcfg_src[k];
                end
                if (dhold[k])
                begin
                    dcnt_r[k] <= 8'h00;
                    dout_r[k] <= 1'b0;
                end
                else if (dtick[k])
                begin
                    dcnt_r[k] <= dend[k] ? 8'h00 : dcnt_r[k] + 8'h01;
                    if (dend[k])
                        dout_r[k] <= ~dout_r[k];
                end
            end
        end
    end

    assign memory_clock_fast = dout_r[0];
    assign memory_clock_slow = dout_r[1];
    assign periph_clock      = dout_r[FB0-1:2];
    assign fabric_clock_out  = dout_r[N_DIV-1:FB0]; // Four fabric clocks

    // ==================================================================
    // Fabric resets: asserted until shifters on, then follow software on rising clock edges
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            frst_r <= 4'h0;
        else
        begin
            for (int j = 0; j < 4; j++)
            begin
                if (!ls_en_r)
                    frst_r[j] <= 1'b0;
                else if (dtick[FB0+j] && dend[FB0+j] && !dout_r[FB0+j]) // Moves with own clock
                    frst_r[j] <= ~fab_cfg_r[j].rst;
            end
        end
    end

    assign fabric_reset_out_n = frst_r;

endmodule

//--- hdl/ckg_pkg.sv
// Constants, register map and carrier types for the processor-side clock generator
package ckg_pkg;

    // ==================================================================
    // Register map (byte addresses on the APB)
    localparam logic [11:0] CKG_PLL_BASE_OFS   = 12'h000; // Three PLL controls, one word each
    localparam logic [11:0] CKG_CPU_RATIO_OFS  = 12'h00C; // CPU ratio set select
    localparam logic [11:0] CKG_MEM_DIV_OFS    = 12'h010; // Memory clock dividers
    localparam logic [11:0] CKG_PERIPH_DIV_OFS = 12'h014; // Peripheral dividers, one byte each
    localparam logic [11:0] CKG_FAB_BASE_OFS   = 12'h020; // Four fabric clock controls
    localparam logic [11:0] CKG_LS_CTRL_OFS    = 12'h030; // Boundary level shifter enable
    localparam logic [11:0] CKG_STATUS_OFS     = 12'h034; // Lock, shifter and port clock status

    // ==================================================================
    // Field positions
    localparam int CKG_PLL_EN_BIT     = 0;  // PLL enable
    localparam int CKG_PLL_BYP_BIT    = 1;  // PLL bypass
    localparam int CKG_PLL_INC_LSB    = 16; // PLL frequency word
    localparam int CKG_MEM_SLOW_LSB   = 8;  // Slow memory divider
    localparam int CKG_FAB_DIV_LSB    = 8;  // Fabric divider
    localparam int CKG_FAB_RST_BIT    = 16; // Fabric reset request
    localparam int CKG_STAT_LS_BIT    = 3;  // Shifters enabled
    localparam int CKG_STAT_ALIVE_LSB = 4;  // Port clock seen toggling

    // ==================================================================
    // Reset values and counts
    localparam logic [15:0] CKG_PLL_INC_RST = 16'h4000; // Frequency word after reset
    localparam logic [7:0]  CKG_DIV_RST     = 8'h01;    // Memory and peripheral divider
    localparam logic [7:0]  CKG_FAB_DIV_RST = 8'h04;    // Fabric divider
    localparam logic [7:0]  CKG_LOCK_EDGES  = 8'h64;    // Reference edges until lock
    localparam logic [3:0]  CKG_CPU_LIM_621 = 4'hB;     // Last phase of slowest period, in PLL ticks, 6:3:2:1
    localparam logic [3:0]  CKG_CPU_LIM_421 = 4'h7;     // Last phase of slowest period, in PLL ticks, 4:2:2:1

    // ==================================================================
    // Fabric source codes; any other code selects the I/O PLL
    localparam logic [1:0] CKG_SRC_CPU = 2'h2;
    localparam logic [1:0] CKG_SRC_DDR = 2'h3;

    // ==================================================================
    // Carrier types
    typedef struct packed {
        logic        en;     // PLL running
        logic        bypass; // Reference fed straight through
        logic [15:0] inc;    // Frequency word
    } ckg_pll_cfg_s;

    typedef struct packed {
        logic [1:0] src; // Source PLL
        logic [7:0] div; // Half period in source ticks
        logic       rst; // Reset request to fabric
    } ckg_fab_cfg_s;

endpackage

//--- tb/ckg_clock_gen_assertions.sv
// Port checker for the clock generator, bound to the design top
module ckg_checker
    import ckg_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cpu_clock_fastest,
    input wire logic        cpu_clock_second,
    input wire logic        cpu_clock_third,
    input wire logic        cpu_clock_slowest,
    input wire logic [3:0]  fabric_clock_out,
    input wire logic [3:0]  fabric_reset_out_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // Decode and shadow of the shifter enable
    wire logic [9:0] word   = paddr[11:2];
    wire logic       acc    = psel && penable;
    wire logic       mapped = (word <= 10'h005) || (word >= 10'h008 && word <= 10'h00D);
    logic            ls_r;
    logic            ls_nxt;
    logic [1:0]      warm_r; // Fastest edges seen, saturating
    assign ls_nxt = (acc && pwrite && word == 10'h00C && pstrb[0]) ? pwdata[0] : ls_r;
    // Shadow registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ls_r <= 1'b0;
            warm_r <= 2'h0;
        end
        else
        begin
            ls_r <= ls_nxt;
            if ($changed(cpu_clock_fastest) && warm_r != 2'h3)
                warm_r <= warm_r + 2'h1;
        end
    end
    // ==========
    // Properties
    a_ready_always: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_decode_err: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr disagrees with decode");
    a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read data not zero");
    a_fab_gated: assert property (!ls_r && !$past(ls_r) |-> fabric_clock_out == 4'h0)
        else $error("fabric clock runs with shifters off");
    a_fab_rst_held: assert property (!ls_r && !$past(ls_r) |-> fabric_reset_out_n == 4'h0)
        else $error("fabric reset released with shifters off");
    a_cpu_aligned: assert property (warm_r == 2'h3 && ($changed(cpu_clock_second)
        || $changed(cpu_clock_slowest)) |-> $rose(cpu_clock_fastest))
        else $error("cpu clock edge not aligned to fastest rise");
    a_cpu_third: assert property (warm_r == 2'h3 && $changed(cpu_clock_third) |-> $changed(cpu_clock_fastest))
        else $error("third cpu clock edge not aligned");
    for (genvar j = 0; j < 4; j++)
    begin : g_rst
        a_rst_with_clk: assert property (ls_r && $past(ls_r) && $changed(fabric_reset_out_n[j])
            |-> $rose(fabric_clock_out[j]))
            else $error("fabric reset moved without clock rise");
    end
endmodule

bind ckg_clock_gen ckg_checker u_chk (.*);

//--- tb/ckg_fabric_model.sv
// Fabric-side model: supplies port clocks, synchronises fabric resets
module ckg_fabric_model
    import ckg_pkg::*;
(
    input wire logic [3:0] port_run,
    input wire logic [3:0] fabric_clock_out,
    input wire logic [3:0] fabric_reset_out_n,
    output logic     [3:0] port_clk,
    output logic     [3:0] rst_sync_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:1] osc = 3'h0; // Own oscillators, unrelated rates
    logic [3:0] meta_n;     // First reset stage
    always #3.5 osc[1] = ~osc[1];
    always #4.5 osc[2] = ~osc[2];
    always #5.5 osc[3] = ~osc[3];
    // Port 0 reuses fabric clock 0; others run free; a stopped port stays low
    assign port_clk = port_run & {osc, fabric_clock_out[0]};
    // Each fabric reset synchronised in its own clock only
    for (genvar j = 0; j < 4; j++)
    begin : g_sync
        always_ff @(posedge fabric_clock_out[j] or negedge fabric_reset_out_n[j])
            if (!fabric_reset_out_n[j])
                {rst_sync_n[j], meta_n[j]} <= 2'h0;
            else
                {rst_sync_n[j], meta_n[j]} <= {meta_n[j], 1'b1};
    end
endmodule

//--- tb/tb_ps_clock_generation.sv
// Self-checking bench for the processor-side clock generator
module tb_ps_clock_generation import ckg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, system_ref_clock, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0]  pstrb, port_run, port_clk, fabric_clock_out, fabric_reset_out_n, rst_sync_n;
    logic        cpu_clock_fastest, cpu_clock_second, cpu_clock_third, cpu_clock_slowest, memory_clock_fast;
    int          error_cnt, tests_run, i;
    wire logic [7:0] mon = {fabric_clock_out[2:0], memory_clock_fast, cpu_clock_slowest, cpu_clock_third,
                            cpu_clock_second, cpu_clock_fastest};
    localparam logic [11:0] RA [11] = '{12'h0, 12'h4, 12'h8, 12'hC, 12'h10, 12'h14, 12'h20, 12'h24, 12'h28,
                                        12'h2C, 12'h30};
    localparam logic [31:0] RV [11] = '{32'h40000003, 32'h40000003, 32'h40000003, 32'h0, 32'h101,
                                        32'h1010101, 32'h400, 32'h400, 32'h400, 32'h400, 32'h0};
    localparam int P621 [4] = '{8, 16, 24, 48};
    localparam int P421 [4] = '{8, 16, 16, 32};
    ckg_clock_gen dut (.*, .memory_clock_slow(), .periph_clock());
    ckg_fabric_model partner (.*);
    // ==========
    // Clocks: 250 MHz bus clock, 33 MHz reference
    always #2 pclk = ~pclk;
    always #15 system_ref_clock = ~system_ref_clock;
    // ==========
    // Verdict and compare helpers
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer, request held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; n < 50 && pready !== 1'b1; n++)
            @(posedge pclk);
        check("bus answer", 32'h1, {31'h0, pready});
        if (n == 50)
            finish_test();
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits for a monitored level, counting cycles
    task automatic wait_lvl(input int idx, input logic v, inout int c);
        int n;
        for (n = 0; n < 400 && mon[idx] !== v; n++)
            @(negedge pclk);
        c += n;
        if (n == 400)
            check("clock timeout", 32'h0, 32'h1);
        if (n == 400)
            finish_test();
    endtask
    // Rise-to-rise period in bus cycles
    task automatic period(input int idx, input int lo, input int hi);
        int c;
        c = 0;
        wait_lvl(idx, 1'b0, c);
        wait_lvl(idx, 1'b1, c);
        c = 0;
        wait_lvl(idx, 1'b0, c);
        wait_lvl(idx, 1'b1, c);
        check($sformatf("period of clock %0d", idx), 32'h1, {31'h0, c >= lo && c <= hi});
    endtask
    // ==========
    // Test sequence
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, system_ref_clock} = '0;
        {pstrb, port_run, error_cnt, tests_run} = {8'hF0, 64'h0};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        check("gated fabric", 32'h0, {24'h0, fabric_clock_out, fabric_reset_out_n});
        for (i = 0; i < 11; i++)
        begin
            apb(1'b0, RA[i], 32'h0);
            check($sformatf("reg %h", RA[i]), RV[i], d);
        end
        apb(1'b0, 12'h018, 32'h0);
        check("unmapped read", 32'h0, d | 32'(!e));
        apb(1'b1, 12'h038, 32'hFFFFFFFF);
        check("unmapped write", 32'h1, {31'h0, e});
        $display("test registers done");
        period(4, 14, 16);
        apb(1'b1, CKG_PLL_BASE_OFS, 32'h40000001);
        repeat (900) @(posedge pclk);
        apb(1'b0, CKG_STATUS_OFS, 32'h0);
        check("cpu lock", 32'h1, d & 32'h1);
        period(4, 14, 16);
        for (i = 0; i < 4; i++)
            period(i, P621[i], P621[i]);
        apb(1'b1, CKG_CPU_RATIO_OFS, 32'h1);
        repeat (100) @(posedge pclk);
        for (i = 0; i < 4; i++)
            period(i, P421[i], P421[i]);
        $display("test plls done");
        apb(1'b1, CKG_FAB_BASE_OFS, 32'h102);
        apb(1'b1, CKG_FAB_BASE_OFS + 12'h8, 32'h203);
        repeat (100) @(posedge pclk);
        check("held fabric", 32'h0, {28'h0, fabric_clock_out});
        apb(1'b1, CKG_LS_CTRL_OFS, 32'h1);
        period(5, 8, 8);
        period(6, 59, 61);
        period(7, 29, 31);
        check("released resets", 32'hFF, {fabric_reset_out_n, rst_sync_n});
        apb(1'b1, CKG_FAB_BASE_OFS + 12'h4, 32'h10400);
        repeat (200) @(posedge pclk);
        check("fabric reset 1", 32'hD, {28'h0, fabric_reset_out_n});
        port_run <= 4'hF;
        repeat (20) @(posedge pclk);
        port_run <= 4'h7;
        repeat (8) @(posedge pclk);
        apb(1'b1, CKG_STATUS_OFS, 32'hF0);
        repeat (20) @(posedge pclk);
        apb(1'b0, CKG_STATUS_OFS, 32'h0);
        check("port activity", 32'h78, d & 32'hF8);
        $display("test fabric done");
        finish_test();
    end
endmodule
